/* include/vbicfg_pkg.sv */
package vbicfg_pkg;
   // Register offsets on the serial register port.
   localparam logic [7:0] VBICFG_OFS_STATUS   = 8'hc0;
   localparam logic [7:0] VBICFG_OFS_ENABLE   = 8'hc1;
   localparam logic [7:0] VBICFG_OFS_IRQCFG   = 8'hc2;
   localparam logic [7:0] VBICFG_OFS_DATA     = 8'hc3;
   localparam logic [7:0] VBICFG_OFS_ADDR_LO  = 8'hc4;
   localparam logic [7:0] VBICFG_OFS_ADDR_HI  = 8'hc5;
   // Reset values.
   localparam logic [7:0] VBICFG_RST_IRQCFG   = 8'h04;
   localparam logic [7:0] VBICFG_RST_DATA     = 8'hdc;
   localparam logic [7:0] VBICFG_RST_ADDR_LO  = 8'h0f;
   localparam logic [7:0] VBICFG_RST_ADDR_HI  = 8'h00;
   localparam logic [7:0] VBICFG_RST_STATUS   = 8'h00;
   localparam logic [7:0] VBICFG_RST_ENABLE   = 8'h00;
   // Field positions in the configuration register.
   localparam int VBICFG_BIT_POL    = 0;
   localparam int VBICFG_BIT_IRQ    = 1;
   localparam int VBICFG_BIT_PIXOE  = 2;
   // Status and enable bits that exist in hardware (others reserved).
   localparam logic [7:0] VBICFG_IRQ_IMPL = 8'h47;
   // Configuration RAM geometry.
   localparam int VBICFG_RAM_BYTES  = 512;
   localparam int VBICFG_SLOTS      = 32;
   localparam int VBICFG_SLOT_BYTES = 16;
   localparam int VBICFG_STD_SLOTS  = 12;
   localparam int VBICFG_AW         = 9;
   localparam logic [8:0] VBICFG_ADDR_LAST = 9'h1ff;
   localparam logic [8:0] VBICFG_CUSTOM_BASE = 9'h1b0;
   localparam logic [8:0] VBICFG_CUSTOM_END  = 9'h1df;

   // One register port access, single cycle.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vbicfg_req_s;
endpackage

/* core/vbicfg_top.sv */
// How it works
// [R01] Output enable bit gates pixel pins drive.
// [R02] Read-only bit mirrors interrupt pin active.
// [R03] Host keeps both polarity bits equal.
// [R04] Polarity bit: zero low, one high.
// [R05] Active-low: drive low or release pin.
// [R06] Active-high: always drive, high when active.
// [R07] RAM is 512 bytes, 32 slots of 16.
// [R08] First twelve slots hold standard services.
// [R09] Two more slots hold custom slicing modes; the custom range 1B0h-1DFh in the code spans three.
// [R10] Data port moves one byte at counter.
// [R11] Counter advances after each data access.
// [R12] Low and high registers load 9-bit counter.
// [R13] Host sets line modes to FFh first.
// [R14] Host clears full field mode first.
// [R15] Host loads suggested constants, custom slots free.
// [R16] Interrupt active when enabled status bit set.
// [R17] Writing one clears a status bit.
// [R18] Counter wraps from 511 to 0.
`timescale 1ns/10ps
`default_nettype none
module vbicfg_top
   import vbicfg_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire vbicfg_pkg::vbicfg_req_s req_i,
   input  wire logic [7:0]            irq_event_i,
   input  wire logic                  pixel_cond_i,
   output logic [7:0]                 rdata_o,
   output logic                       pixel_output_pins_oe_o,
   output logic                       irq_o,
   output logic                       irq_oe_o,
   output logic                       irq_active_o
);
   import vbicfg_pkg::*;

   logic [7:0]           ram [VBICFG_RAM_BYTES];
   logic [VBICFG_AW-1:0] ptr;
   logic [VBICFG_AW-1:0] next_ptr;
   logic [7:0]           status;
   logic [7:0]           next_status;
   logic [7:0]           enable;
   logic [7:0]           next_enable;
   logic                 pixoe;
   logic                 next_pixoe;
   logic                 pol;
   logic                 next_pol;
   logic [7:0]           next_rdata;
   logic                 active;
   logic                 data_hit;
   logic                 ram_we;
   logic [7:0]           ram_at_ptr;
   logic                 next_pix_oe;
   logic                 next_irq;
   logic                 next_irq_oe;
   logic                 next_irq_active;

   // Byte under the counter, named so the checks below can look back at it.
   assign ram_at_ptr = ram[ptr];
   assign data_hit = (req_i.wr | req_i.rd) && (req_i.addr == VBICFG_OFS_DATA);
   assign ram_we   = req_i.wr && (req_i.addr == VBICFG_OFS_DATA);
   // Pending and enabled sources raise the interrupt.
   assign active   = |(status & enable); // [R16]

   // Next register state; a load of the counter wins over an increment.
   always_comb begin
      next_ptr    = ptr;
      next_pixoe  = pixoe;
      next_pol    = pol;
      next_enable = enable;
      // New events win over a same-cycle write-one clear.
      next_status = status;
      if (req_i.wr && req_i.addr == VBICFG_OFS_STATUS) begin
         next_status = status & ~req_i.wdata; // [R17]
      end
      next_status = (next_status | irq_event_i) & VBICFG_IRQ_IMPL;
      if (data_hit) begin
         // Wrap is explicit: the last address is followed by zero.
         next_ptr = (ptr == VBICFG_ADDR_LAST) ? '0 : ptr + 9'h001; // [R11] [R18]
      end
      if (req_i.wr) begin
         unique case (req_i.addr)
            VBICFG_OFS_ENABLE:  next_enable = req_i.wdata & VBICFG_IRQ_IMPL;
            VBICFG_OFS_IRQCFG: begin
               next_pixoe = req_i.wdata[VBICFG_BIT_PIXOE]; // [R01]
               next_pol   = req_i.wdata[VBICFG_BIT_POL]; // [R04]
            end
            VBICFG_OFS_ADDR_LO: next_ptr = {ptr[8], req_i.wdata}; // [R12]
            VBICFG_OFS_ADDR_HI: next_ptr = {req_i.wdata[0], ptr[7:0]}; // [R12]
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ptr    <= {VBICFG_RST_ADDR_HI[0], VBICFG_RST_ADDR_LO};
         status <= VBICFG_RST_STATUS;
         enable <= VBICFG_RST_ENABLE;
         pixoe  <= VBICFG_RST_IRQCFG[VBICFG_BIT_PIXOE];
         pol    <= VBICFG_RST_IRQCFG[VBICFG_BIT_POL];
      end else begin
         ptr    <= next_ptr;
         status <= next_status;
         enable <= next_enable;
         pixoe  <= next_pixoe;
         pol    <= next_pol;
      end
   end

   // The RAM has no reset; software loads every slot it uses.
   always_ff @(posedge clk_i) begin
      if (ram_we) begin
         ram[ptr] <= req_i.wdata; // [R07] [R08] [R09] [R10]
      end
   end

   // Read data, registered so the output comes from a flip-flop.
   always_comb begin
      next_rdata = 8'h00;
      if (req_i.rd) begin
         unique case (req_i.addr)
            VBICFG_OFS_STATUS:  next_rdata = status;
            VBICFG_OFS_ENABLE:  next_rdata = enable;
            VBICFG_OFS_IRQCFG:  next_rdata = {5'h00, pixoe, active, pol}; // [R02]
            VBICFG_OFS_DATA:    next_rdata = ram[ptr]; // [R10]
            VBICFG_OFS_ADDR_LO: next_rdata = ptr[7:0];
            VBICFG_OFS_ADDR_HI: next_rdata = {7'h00, ptr[8]};
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   // Next pin values: open drain when active low, push-pull when active high.
   // Registering the pins costs one cycle of interrupt latency but keeps
   // decode glitches off the shared open-drain line.
   always_comb begin
      next_pix_oe     = pixoe & pixel_cond_i; // [R01]
      next_irq_active = active;
      next_irq        = pol & active; // [R05] [R06]
      next_irq_oe     = pol | active; // [R05] [R06]
   end

   // Output registers only; every decision is made above.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o                <= 8'h00;
         pixel_output_pins_oe_o <= 1'b0;
         irq_o                  <= 1'b0;
         irq_oe_o               <= 1'b0;
         irq_active_o           <= 1'b0;
      end else begin
         rdata_o                <= next_rdata;
         pixel_output_pins_oe_o <= next_pix_oe; // [R01]
         irq_active_o           <= next_irq_active;
         irq_o                  <= next_irq; // [R05] [R06]
         irq_oe_o               <= next_irq_oe; // [R05] [R06]
      end
   end

   // Checks on the registered pin and counter behaviour.
   // The pixel enable follows the bit and the outside condition a cycle late.
   AST_PIX_OE: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      1'b1 |=> pixel_output_pins_oe_o == $past(pixoe & pixel_cond_i))
      else $error("pixel output enable wrong");

   // The read-only state bit tells the same story as the pin.
   AST_IRQ_BIT: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R02]
      req_i.rd && req_i.addr == VBICFG_OFS_IRQCFG |=> rdata_o[VBICFG_BIT_IRQ] == irq_active_o)
      else $error("interrupt state bit wrong");

   // Active low and asserted: the pin is pulled down.
   AST_OD_LOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05]
      !pol && active ##1 !pol |-> irq_oe_o && !irq_o)
      else $error("active low not driven low");

   // Active low and idle: the pin is left to the pull-up.
   AST_OD_REL: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05] [R04]
      !pol && !active ##1 !pol |-> !irq_oe_o)
      else $error("active low not released");

   // Active high: the pin is always driven and follows the request.
   AST_PP: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R06]
      pol |=> irq_oe_o && irq_o == $past(active))
      else $error("active high drive wrong");

   // Every data port access moves the counter on by one.
   AST_INC: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11] [R18]
      data_hit |=> ptr == (($past(ptr) == VBICFG_ADDR_LAST) ? 9'h000 : $past(ptr) + 9'h001))
      else $error("counter did not advance");

   // A low address write loads the low eight counter bits.
   AST_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
      req_i.wr && req_i.addr == VBICFG_OFS_ADDR_LO |=> ptr[7:0] == $past(req_i.wdata))
      else $error("counter low load failed");

   // Writing one with no competing event clears the status bit.
   AST_CLR: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R17]
      req_i.wr && req_i.addr == VBICFG_OFS_STATUS && req_i.wdata[0] && !irq_event_i[0]
      |=> !status[0])
      else $error("status bit not cleared");

   // The interrupt is the OR of enabled pending sources.
   AST_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R16]
      irq_active_o == $past(|(status & enable)))
      else $error("interrupt not tied to status");

   // With no read the data output rests at zero.
   AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
      !req_i.rd |=> rdata_o == 8'h00)
      else $error("read data not idle");

   // A data port read returns the byte under the counter.
   AST_RD_RAM: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
      req_i.rd && req_i.addr == VBICFG_OFS_DATA |=> rdata_o == $past(ram_at_ptr))
      else $error("data port read wrong");

   // A high address write loads bit 8 and keeps the rest.
   AST_LOAD_HI: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
      req_i.wr && req_i.addr == VBICFG_OFS_ADDR_HI
      |=> ptr[8] == $past(req_i.wdata[0]) && ptr[7:0] == $past(ptr[7:0]))
      else $error("counter high load failed");

   // A low address write keeps bit 8.
   AST_LOAD_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
      req_i.wr && req_i.addr == VBICFG_OFS_ADDR_LO |=> ptr[8] == $past(ptr[8]))
      else $error("counter bit 8 lost");

   // Without an access or a load the counter holds still.
   AST_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
      !data_hit && !(req_i.wr && (req_i.addr == VBICFG_OFS_ADDR_LO
      || req_i.addr == VBICFG_OFS_ADDR_HI)) |=> $stable(ptr))
      else $error("counter moved on its own");

   // The last location is followed by the first.
   AST_WRAP: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R18]
      data_hit && ptr == VBICFG_ADDR_LAST |=> ptr == 9'h000)
      else $error("counter did not wrap");

   // An event in the same cycle as a clear still leaves the bit set.
   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R17]
      irq_event_i[0] |=> status[0])
      else $error("status event lost");

   // Reserved status bits never become set.
   AST_RSV_STATUS: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R16]
      (status & ~VBICFG_IRQ_IMPL) == 8'h00)
      else $error("reserved status bit set");

   // Reserved enable bits never become set.
   AST_RSV_ENABLE: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R16]
      (enable & ~VBICFG_IRQ_IMPL) == 8'h00)
      else $error("reserved enable bit set");

   // A cleared enable bit floats the pixel pins.
   AST_PIX_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      !pixoe |=> !pixel_output_pins_oe_o)
      else $error("pixel pins not floated");

   // Enable bit and outside condition together drive the pixel pins.
   AST_PIX_ON: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      pixoe && pixel_cond_i |=> pixel_output_pins_oe_o)
      else $error("pixel pins not driven");

   // A configuration write loads the polarity bit.
   AST_POL_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R04]
      req_i.wr && req_i.addr == VBICFG_OFS_IRQCFG |=> pol == $past(req_i.wdata[VBICFG_BIT_POL]))
      else $error("polarity not loaded");

   // A configuration write loads the pixel enable bit.
   AST_PIXOE_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      req_i.wr && req_i.addr == VBICFG_OFS_IRQCFG
      |=> pixoe == $past(req_i.wdata[VBICFG_BIT_PIXOE]))
      else $error("pixel enable not loaded");

   // Active low never drives the pin high.
   AST_OD_NO_HIGH: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05]
      !pol |=> !irq_o)
      else $error("active low drove high");

   // Active high and idle: the pin is driven low.
   AST_PP_LOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R06]
      pol && !active |=> irq_oe_o && !irq_o)
      else $error("active high idle not low");

   // A status read returns the pending bits.
   AST_RD_STATUS: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R17]
      req_i.rd && req_i.addr == VBICFG_OFS_STATUS |=> rdata_o == $past(status))
      else $error("status read wrong");

   // A configuration read shows both bits and zero reserved bits.
   AST_RD_CFG: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R04]
      req_i.rd && req_i.addr == VBICFG_OFS_IRQCFG |=> rdata_o[7:3] == 5'h00
      && rdata_o[VBICFG_BIT_PIXOE] == $past(pixoe) && rdata_o[VBICFG_BIT_POL] == $past(pol))
      else $error("configuration read wrong");

   // The high address register reads only bit 8.
   AST_RD_HI: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
      req_i.rd && req_i.addr == VBICFG_OFS_ADDR_HI |=> rdata_o[7:1] == 7'h00)
      else $error("high address read wrong");

   // Main scenarios: wrap, custom slot write and both pin styles.
   COV_WRAP: cover property (@(posedge clk_i) disable iff (!resetn_i)
      data_hit && ptr == VBICFG_ADDR_LAST);
   COV_CUSTOM: cover property (@(posedge clk_i) disable iff (!resetn_i)
      ram_we && ptr == VBICFG_CUSTOM_BASE);
   COV_PP: cover property (@(posedge clk_i) disable iff (!resetn_i) pol && active);
   COV_OD: cover property (@(posedge clk_i) disable iff (!resetn_i) !pol && active);
endmodule
`default_nettype wire

/* bench/vbicfg_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Host on the register port; a request launches on an edge and is taken on the next.
module vbicfg_host
   import vbicfg_pkg::*;
(
   input  wire logic               clk_i,
   output var vbicfg_pkg::vbicfg_req_s req_o
);
   initial req_o = '0;
   // No release between accesses, so back-to-back traffic never rewrites req_o twice.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
   endtask
   task automatic idle();
      req_o <= '0;
      @(posedge clk_i);
   endtask
   // Line modes at FFh and full field off before any RAM access.
   task automatic prep(input logic pol);
      for (int a = 8'hd0; a <= 8'hfb; a++) acc(1'b1, 8'(a), 8'hff);
      acc(1'b1, 8'hcf, 8'h00);
      acc(1'b1, 8'h1e, {7'h00, pol});
   endtask
endmodule
`default_nettype wire

/* bench/vbi_config_ram_and_irq_pin_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module vbi_config_ram_and_irq_pin_tb;
   import vbicfg_pkg::*;
   logic        clk_i, resetn_i, pixel_cond_i, rd_d, pix, iq, ioe, iact, pixoe, pol;
   logic [7:0]  irq_event_i, rdata_o, st, en, ram [512], q [$];
   vbicfg_req_s req;
   int          errors, check_count, ptr;
   vbicfg_host host (.clk_i(clk_i), .req_o(req));
   vbicfg_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
      .irq_event_i(irq_event_i), .pixel_cond_i(pixel_cond_i), .rdata_o(rdata_o),
      .pixel_output_pins_oe_o(pix), .irq_o(iq), .irq_oe_o(ioe), .irq_active_o(iact));
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read data stands one cycle after the taking edge and is zero otherwise.
   always @(posedge clk_i) rd_d <= req.rd;
   always @(negedge clk_i) begin
      if (resetn_i === 1'b1) cmp(rdata_o, (rd_d === 1'b1) ? q.pop_front() : 8'h00);
   end
   function automatic logic [7:0] mread(input logic [7:0] a);
      case (a)
         VBICFG_OFS_STATUS:  return st;
         VBICFG_OFS_ENABLE:  return en;
         VBICFG_OFS_IRQCFG:  return {5'h00, pixoe, |(st & en), pol};
         VBICFG_OFS_DATA:    return ram[ptr];
         VBICFG_OFS_ADDR_LO: return ptr[7:0];
         VBICFG_OFS_ADDR_HI: return {7'h00, ptr[8]};
         default:            return 8'h00;
      endcase
   endfunction
   task automatic rd(input logic [7:0] a);
      q.push_back(mread(a));
      if (a == VBICFG_OFS_DATA) ptr = (ptr + 1) % 512;
      host.acc(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      case (a)
         VBICFG_OFS_STATUS:  st &= ~d;
         VBICFG_OFS_ENABLE:  en = d & VBICFG_IRQ_IMPL;
         VBICFG_OFS_IRQCFG:  {pixoe, pol} = {d[2], d[0]};
         VBICFG_OFS_DATA: begin
            ram[ptr] = d;
            ptr = (ptr + 1) % 512;
         end
         VBICFG_OFS_ADDR_LO: ptr[7:0] = d;
         VBICFG_OFS_ADDR_HI: ptr[8] = d[0];
         default: ;
      endcase
      host.acc(1'b1, a, d);
   endtask
   task automatic seek(input logic [8:0] a);
      wr(VBICFG_OFS_ADDR_HI, {7'h00, a[8]});
      wr(VBICFG_OFS_ADDR_LO, a[7:0]);
   endtask
   // Pins are compared once the port has been quiet for two edges.
   task automatic chk();
      logic c;
      logic a;
      c = 1'($urandom);
      a = |(st & en);
      pixel_cond_i <= c;
      host.idle();
      host.idle();
      #1;
      cmp({iact, ioe, iq, pix}, {a, pol | a, pol & a, pixoe & c});
      @(posedge clk_i);
   endtask
   // Watchdog far beyond the couple of hundred cycles the run needs.
   initial begin
      #50us;
      errors++;
      summarize();
   end
   initial begin
      logic [7:0] d;
      logic [8:0] b;
      {errors, check_count, ptr, st, en, pixoe, pol} = {32'd0, 32'd0, 32'd15, 16'h0, 2'b10};
      {resetn_i, pixel_cond_i, irq_event_i} = '0;
      void'($urandom(69621));
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      host.prep(1'b0);
      for (int i = 7; i >= 0; i--) rd(8'hc0 | 8'(i % 3) | 8'(i / 3 * 4) | 8'(i / 6 * 8'h7f));
      chk();
      wr(VBICFG_OFS_ENABLE, 8'hff);
      d = 8'($urandom) | 8'h01;
      irq_event_i <= d;
      host.idle();
      irq_event_i <= 8'h00;
      st = d & VBICFG_IRQ_IMPL;
      chk();
      rd(VBICFG_OFS_STATUS);
      for (int i = 0; i < 4; i++) begin
         d = (8'($urandom) & 8'hfa) | 8'(i % 2) | 8'(i / 2 * 4);
         wr(VBICFG_OFS_IRQCFG, d);
         wr(8'h1e, {7'h00, d[0]});
         rd(VBICFG_OFS_IRQCFG);
         chk();
      end
      wr(VBICFG_OFS_STATUS, 8'hff);
      chk();
      for (int i = 0; i < 6; i++) begin
         b = (i == 0) ? 9'h1fe : (i == 1) ? VBICFG_CUSTOM_BASE : 9'($urandom);
         seek(b);
         repeat (4) wr(VBICFG_OFS_DATA, 8'($urandom));
         seek(b);
         repeat (4) rd(VBICFG_OFS_DATA);
         rd(VBICFG_OFS_ADDR_LO);
         rd(VBICFG_OFS_ADDR_HI);
      end
      host.idle();
      host.idle();
      summarize();
   end
endmodule
`default_nettype wire
